// ---- inc/spims_pkg.sv ----
`default_nettype none
package spims_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_DATA    = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h0C;
  // port_control_reg fields
  localparam int CTL_BIT_ORDER = 7;
  localparam int CTL_MASTER    = 6;
  localparam int CTL_PHASE     = 5;
  localparam int CTL_POLARITY  = 4;
  localparam int CTL_SS_DIS    = 3;
  localparam int CTL_RATE_HI   = 2;
  localparam int CTL_RATE_LO   = 0;
  // port_status_reg fields
  localparam int STA_ENABLE    = 7;
  localparam int STA_DONE      = 6;
  localparam int STA_MODE_FLT  = 5;
  localparam int STA_COLLIDE   = 4;
  localparam int STA_OVERRUN   = 3;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;
  // bits per byte and sck half-periods per byte
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [4:0] BYTE_EDGES  = 5'h10;
  // half-period terminal counts for rate_select codes
  localparam logic [5:0] HALF_DIV4   = 6'h01;
  localparam logic [5:0] HALF_DIV8   = 6'h03;
  localparam logic [5:0] HALF_DIV16  = 6'h07;
  localparam logic [5:0] HALF_DIV32  = 6'h0F;
  localparam logic [5:0] HALF_DIV64  = 6'h1F;
  localparam logic [5:0] HALF_DIV128 = 6'h3F;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
`default_nettype wire

// ---- inc/spims_baud_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface spims_baud_if;
  logic [2:0] rate;
  logic       run;
  logic       tick;
  modport ctl (output rate, output run, input tick);
  modport gen (input rate, input run, output tick);
endinterface
`default_nettype wire

// ---- hw/spims_baud.sv ----
`timescale 1ns/1ns
`default_nettype none
module spims_baud (
  input  wire logic   i_clk,
  input  wire logic   i_reset_n,
  spims_baud_if.gen   bif
);
  logic [5:0] cnt_r;
  logic [5:0] lim;

  always_comb begin
    unique case (bif.rate)
      3'h0: lim = spims_pkg::HALF_DIV4;
      3'h1: lim = spims_pkg::HALF_DIV8;
      3'h2: lim = spims_pkg::HALF_DIV16;
      3'h3: lim = spims_pkg::HALF_DIV32;
      3'h4: lim = spims_pkg::HALF_DIV64;
      default: lim = spims_pkg::HALF_DIV128;
    endcase
  end

  // one tick per sck half period
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !bif.run || cnt_r == lim) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  assign bif.tick = bif.run && (cnt_r == lim);

  property p_tick_gap;
    @(posedge i_clk) disable iff (!i_reset_n) bif.tick |=> !bif.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("sck half period below two clocks");

  property p_div4;
    @(posedge i_clk) disable iff (!i_reset_n)
      (bif.tick && bif.rate == 3'h0) ##1 (bif.run && bif.rate == 3'h0) |-> ##1 bif.tick;
  endproperty
  a_div4: assert property (p_div4) else $error("rate code 000 not dividing by four");
endmodule // spims_baud
`default_nettype wire

// ---- hw/spims_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module spims_top (
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic        I_SCK,
  output logic             O_SCK,
  output logic             O_SCK_OE,
  input  wire logic        I_MOSI,
  output logic             O_MOSI,
  output logic             O_MOSI_OE,
  input  wire logic        I_MISO,
  output logic             O_MISO,
  output logic             O_MISO_OE,
  input  wire logic        I_SS_N,
  output logic             O_IRQ
);
  logic [7:0] ctl_r;
  logic       spen_r, transfer_done_flag_r, mode_fault_flag_r, write_collision_flag_r, overrun_flag_r, irq_en_r;
  logic [7:0] tx_sh_r, rx_sh_r, rx_buf_r;
  logic [3:0] bit_cnt_r;
  logic [4:0] edge_cnt_r;
  logic       busy_r, sck_lvl_r;
  logic [3:0] sync1_r, sync2_r;
  logic       sck_d_r;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [7:0] rd_val;
  logic       addr_ok, wr_data, wr_ctl, wr_sta, wr_ien;
  logic       dir, master_select, clock_phase_sel, clock_polarity_sel, select_input_disable;
  logic       ss_low, s_sel, s_rise, s_fall, s_lead, s_trail;
  logic       m_tick, m_lead, m_trail, lead, trail;
  logic       sample_ev, shift_ev, din, out_bit, m_done, s_done, done, occupied;
  logic       mode_fault_flag_ev;
  logic [7:0] rx_shifted, rx_cap;

  spims_baud_if bif ();

  spims_baud u_baud (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .bif       (bif)
  );

  assign dir   = ctl_r[spims_pkg::CTL_BIT_ORDER];
  assign master_select  = ctl_r[spims_pkg::CTL_MASTER];
  assign clock_phase_sel  = ctl_r[spims_pkg::CTL_PHASE];
  assign clock_polarity_sel  = ctl_r[spims_pkg::CTL_POLARITY];
  assign select_input_disable = ctl_r[spims_pkg::CTL_SS_DIS];
  assign bif.rate = ctl_r[spims_pkg::CTL_RATE_HI:spims_pkg::CTL_RATE_LO];
  assign bif.run  = busy_r;

  // bus slave: address phase taken when selected, nonseq and hready
  assign addr_ok = I_HSEL && I_HREADY && (I_HTRANS == spims_pkg::HTRANS_NONSEQ);
  assign wr_data = wr_pend_r && (wr_addr_r == spims_pkg::OFS_DATA);
  assign wr_ctl  = wr_pend_r && (wr_addr_r == spims_pkg::OFS_CONTROL);
  assign wr_sta  = wr_pend_r && (wr_addr_r == spims_pkg::OFS_STATUS);
  assign wr_ien  = wr_pend_r && (wr_addr_r == spims_pkg::OFS_IRQ_EN);

  always_comb begin
    unique case (I_HADDR[7:0])
      spims_pkg::OFS_DATA:    rd_val = rx_buf_r;
      spims_pkg::OFS_CONTROL: rd_val = ctl_r;
      spims_pkg::OFS_STATUS:  rd_val = {spen_r, transfer_done_flag_r, mode_fault_flag_r, write_collision_flag_r, overrun_flag_r, 3'h0};
      spims_pkg::OFS_IRQ_EN:  rd_val = {7'h00, irq_en_r};
      default:                rd_val = 8'h00;
    endcase
    if (I_HADDR[31:8] != 24'h000000) begin
      rd_val = 8'h00;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      O_HRDATA    <= 32'h00000000;
      O_HREADYOUT <= 1'b0;
      O_HRESP     <= 1'b0;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      wr_pend_r   <= addr_ok && I_HWRITE && (I_HADDR[31:8] == 24'h000000);
      wr_addr_r   <= I_HADDR[7:0];
      if (addr_ok && !I_HWRITE) begin
        O_HRDATA <= {24'h000000, rd_val};
      end
    end
  end

  // pin synchronisers: 0 sck, 1 mosi, 2 miso, 3 select
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
      sck_d_r <= 1'b1;
    end else begin
      sync1_r <= {I_SS_N, I_MISO, I_MOSI, I_SCK};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[0];
    end
  end

  assign ss_low = !sync2_r[3];
  assign s_sel  = spen_r && !master_select && (ss_low || (clock_phase_sel && select_input_disable));
  assign s_rise = sync2_r[0] && !sck_d_r;
  assign s_fall = !sync2_r[0] && sck_d_r;
  assign s_lead  = s_sel && (clock_polarity_sel ? s_fall : s_rise);
  assign s_trail = s_sel && (clock_polarity_sel ? s_rise : s_fall);
  assign m_tick  = spen_r && master_select && busy_r && bif.tick;
  assign m_lead  = m_tick && !edge_cnt_r[0];
  assign m_trail = m_tick && edge_cnt_r[0];
  assign lead    = master_select ? m_lead : s_lead;
  assign trail   = master_select ? m_trail : s_trail;
  // sample on first or second edge of each bit
  assign sample_ev = clock_phase_sel ? trail : lead;
  assign shift_ev  = (clock_phase_sel ? lead : trail) && (bit_cnt_r != 4'h0);
  assign din       = master_select ? sync2_r[2] : sync2_r[1];
  assign out_bit   = dir ? tx_sh_r[0] : tx_sh_r[7];
  assign rx_shifted = dir ? {din, rx_sh_r[7:1]} : {rx_sh_r[6:0], din};
  assign rx_cap    = sample_ev ? rx_shifted : rx_sh_r;
  assign m_done = m_tick && (edge_cnt_r == spims_pkg::BYTE_EDGES - 5'h01);
  assign s_done = !master_select && sample_ev && (bit_cnt_r == spims_pkg::BYTE_BITS - 4'h1);
  assign done   = m_done || s_done;
  assign occupied = master_select ? busy_r : (bit_cnt_r != 4'h0);
  // select low on an enabled master with select in use
  assign mode_fault_flag_ev = spen_r && master_select && !select_input_disable && ss_low;

  // shift engine
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N || !spen_r) begin
      tx_sh_r    <= spims_pkg::DATA_RST;
      rx_sh_r    <= spims_pkg::DATA_RST;
      bit_cnt_r  <= 4'h0;
      edge_cnt_r <= 5'h00;
      busy_r     <= 1'b0;
      sck_lvl_r  <= 1'b0;
    end else begin
      if (wr_data && !occupied) begin
        tx_sh_r <= I_HWDATA[7:0];
        busy_r  <= master_select;
      end else if (shift_ev) begin
        tx_sh_r <= dir ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
      end
      if (sample_ev) begin
        rx_sh_r <= rx_shifted;
      end
      if (done || (!master_select && !s_sel)) begin
        bit_cnt_r <= 4'h0;
      end else if (sample_ev) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (m_done || !master_select) begin
        busy_r     <= (wr_data && !occupied) ? master_select : 1'b0;
        edge_cnt_r <= 5'h00;
        sck_lvl_r  <= 1'b0;
      end else if (m_tick) begin
        edge_cnt_r <= edge_cnt_r + 5'h01;
        sck_lvl_r  <= !sck_lvl_r;
      end
    end
  end

  // control register; mode fault drops master mode
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      ctl_r    <= spims_pkg::CONTROL_RST;
      irq_en_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_r <= I_HWDATA[7:0];
      end
      if (mode_fault_flag_ev) begin
        ctl_r[spims_pkg::CTL_MASTER] <= 1'b0;
      end
      if (wr_ien) begin
        irq_en_r <= I_HWDATA[0];
      end
    end
  end

  // status flags: software writes 0 to clear, hardware set wins
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      spen_r   <= 1'b0;
      transfer_done_flag_r   <= 1'b0;
      mode_fault_flag_r   <= 1'b0;
      write_collision_flag_r   <= 1'b0;
      overrun_flag_r   <= 1'b0;
      rx_buf_r <= spims_pkg::DATA_RST;
    end else begin
      if (wr_sta) begin
        spen_r <= I_HWDATA[spims_pkg::STA_ENABLE];
        transfer_done_flag_r <= transfer_done_flag_r && I_HWDATA[spims_pkg::STA_DONE];
        mode_fault_flag_r <= mode_fault_flag_r && I_HWDATA[spims_pkg::STA_MODE_FLT];
        write_collision_flag_r <= write_collision_flag_r && I_HWDATA[spims_pkg::STA_COLLIDE];
        overrun_flag_r <= overrun_flag_r && I_HWDATA[spims_pkg::STA_OVERRUN];
      end
      if (done) begin
        if (transfer_done_flag_r) begin
          overrun_flag_r <= 1'b1;
        end else begin
          transfer_done_flag_r   <= 1'b1;
          rx_buf_r <= rx_cap;
        end
      end
      if (wr_data && occupied) begin
        write_collision_flag_r <= 1'b1;
      end
      if (mode_fault_flag_ev) begin
        mode_fault_flag_r <= 1'b1;
        spen_r <= 1'b0;
      end
    end
  end

  // registered pins
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      O_SCK     <= 1'b0;
      O_SCK_OE  <= 1'b0;
      O_MOSI    <= 1'b0;
      O_MOSI_OE <= 1'b0;
      O_MISO    <= 1'b0;
      O_MISO_OE <= 1'b0;
      O_IRQ     <= 1'b0;
    end else begin
      O_SCK     <= sck_lvl_r ^ clock_polarity_sel;
      O_SCK_OE  <= spen_r && master_select;
      O_MOSI    <= out_bit;
      O_MOSI_OE <= spen_r && master_select;
      O_MISO    <= out_bit;
      O_MISO_OE <= s_sel;
      O_IRQ     <= irq_en_r && (transfer_done_flag_r || (mode_fault_flag_r && !select_input_disable));
    end
  end

  property p_unsel_float;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (!master_select && !ss_low && !(clock_phase_sel && select_input_disable)) |=> !O_MISO_OE;
  endproperty
  a_unsel_float: assert property (p_unsel_float) else $error("unselected slave drives miso");

  property p_unsel_count;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (spen_r && !master_select && !s_sel) |=> (bit_cnt_r == 4'h0);
  endproperty
  a_unsel_count: assert property (p_unsel_count) else $error("unselected slave counted bits");

  property p_cnt_max;
    @(posedge I_MCLK) disable iff (!I_RESET_N) bit_cnt_r <= spims_pkg::BYTE_BITS;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("bit count beyond one byte");

  property p_start;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (spen_r && master_select && wr_data && !busy_r && !mode_fault_flag_ev) |=> busy_r ##[1:64] bif.tick;
  endproperty
  a_start: assert property (p_start) else $error("idle master write did not start");

  property p_collide;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (wr_data && occupied && spen_r) |=> write_collision_flag_r;
  endproperty
  a_collide: assert property (p_collide) else $error("busy write did not flag collision");

  property p_done;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (done && !transfer_done_flag_r) |=> (transfer_done_flag_r && rx_buf_r == $past(rx_cap));
  endproperty
  a_done: assert property (p_done) else $error("byte end not flagged or stored");

  property p_overrun;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (done && transfer_done_flag_r) |=> (overrun_flag_r && $stable(rx_buf_r));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost old byte");

  property p_no_mode_fault_flag;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (master_select && select_input_disable && !mode_fault_flag_r && !(wr_sta || wr_ctl)) |=> !mode_fault_flag_r;
  endproperty
  a_no_mode_fault_flag: assert property (p_no_mode_fault_flag) else $error("mode fault with select disabled");

  property p_idle_sck;
    @(posedge I_MCLK) disable iff (!I_RESET_N)
      (!spen_r && !wr_ctl) ##1 (!spen_r && !wr_ctl) |-> ##1 (O_SCK == clock_polarity_sel && !O_MISO_OE);
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("disabled port not idle");
endmodule // spims_top
`default_nettype wire

// ---- tb/spims_peer.sv ----
`timescale 1ns/1ns
`default_nettype none
module spims_peer (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ss_n,
  input  wire logic       i_clock_polarity_sel,
  input  wire logic       i_lsb,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  logic [7:0] tx_r = 8'h00;
  logic [3:0] n_r = 4'h8;
  logic       last_r = 1'b0;
  logic       cur;
  assign cur = i_lsb ? tx_r[0] : tx_r[7];
  // byte is loaded as select falls so bit one leads the first edge
  always @(negedge i_ss_n) begin
    tx_r = i_tx;
    n_r = 4'h0;
  end
  // leading edge samples, trailing edge shifts, eight bits
  always @(i_sck) begin
    if (!i_ss_n && n_r < 4'h8) begin
      if (i_sck != i_clock_polarity_sel) begin
        o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      end else begin
        tx_r = i_lsb ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
        n_r = n_r + 4'h1;
      end
    end
  end
  // a released line shows the inverse of the last bit
  always @(i_ss_n or cur) begin
    if (!i_ss_n) begin
      o_miso = cur;
      last_r = cur;
    end else begin
      o_miso = ~last_r;
    end
  end
endmodule // spims_peer
`default_nettype wire

// ---- tb/test_spi_master_slave_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_spi_master_slave_port;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hrdy, hresp, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq;
  logic        tb_sck = 1'b0;
  logic        tb_mosi = 1'b0;
  logic        tb_ss_n = 1'b1;
  logic        p_ss_n = 1'b1;
  logic        p_clock_polarity_sel = 1'b0;
  logic        p_lsb = 1'b0;
  logic [7:0]  p_tx = 8'h00;
  logic [7:0]  p_rx, v8;
  logic        p_miso;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n;
  wire logic   sck_w = sck_oe ? sck_o : tb_sck;
  wire logic   mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire logic   miso_w = miso_oe ? miso_o : p_miso;
  always #10 clk = ~clk;
  spims_top uut (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
    .I_SCK(sck_w), .O_SCK(sck_o), .O_SCK_OE(sck_oe),
    .I_MOSI(mosi_w), .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe),
    .I_MISO(miso_w), .O_MISO(miso_o), .O_MISO_OE(miso_oe),
    .I_SS_N(tb_ss_n), .O_IRQ(irq)
  );
  spims_peer peer (
    .i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(p_ss_n), .i_clock_polarity_sel(p_clock_polarity_sel),
    .i_lsb(p_lsb), .i_tx(p_tx), .o_miso(p_miso), .o_rx(p_rx)
  );
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // registered ready is read right after the edge, so this is its sampled value
  task automatic edge_rdy();
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (hrdy === 1'b1) return;
    end
    n_errors++;
    stop_test();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= spims_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(w, q, e);
  endtask
  task automatic wait_bit(input int b);
    logic [31:0] q;
    for (int k = 0; k < 1000; k++) begin
      bus(1'b0, spims_pkg::OFS_STATUS, 32'h0, q);
      if (q[b] === 1'b1) return;
    end
    n_errors++;
    stop_test();
  endtask
  task automatic half_len(output int c);
    logic s;
    s = sck_o;
    c = 0;
    for (int k = 0; k < 300 && sck_o === s; k++) @(posedge clk);
    s = sck_o;
    for (int k = 0; k < 300 && sck_o === s; k++) begin
      @(posedge clk);
      c++;
    end
  endtask
  // polarity 0 byte as remote master, half period of eight clocks, phase ph
  task automatic spi_byte(input logic ph, input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      if (!ph) tb_mosi <= d[i];
      repeat (8) @(posedge clk);
      tb_sck <= 1'b1;
      if (ph) tb_mosi <= d[i];
      if (!ph) q = {q[6:0], miso_w};
      repeat (8) @(posedge clk);
      tb_sck <= 1'b0;
      if (ph) q = {q[6:0], miso_w};
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] d, input logic [7:0] s);
    p_ss_n <= 1'b1;
    @(posedge clk);
    p_tx <= s;
    p_ss_n <= 1'b0;
    wr(spims_pkg::OFS_DATA, d);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc("control", spims_pkg::OFS_CONTROL, 32'h0);
    rdc("status", spims_pkg::OFS_STATUS, 32'h0);
    wr(8'h10, 8'hFF);
    rdc("unmapped", 8'h10, 32'h0);
    chk("hresp", hresp, 32'h0);
    $display("test reset done");
    wr(spims_pkg::OFS_CONTROL, 8'h42);
    wr(spims_pkg::OFS_STATUS, 8'h80);
    wr(spims_pkg::OFS_IRQ_EN, 8'h01);
    chk("sck idle", sck_o, 32'h0);
    xfer(8'hA5, 8'h3C);
    wr(spims_pkg::OFS_DATA, 8'h5A);
    wait_bit(spims_pkg::STA_DONE);
    rdc("status", spims_pkg::OFS_STATUS, 32'hD0);
    chk("irq", irq, 32'h1);
    rdc("rx", spims_pkg::OFS_DATA, 32'h3C);
    chk("peer rx", p_rx, 32'hA5);
    xfer(8'h22, 8'h11);
    wait_bit(spims_pkg::STA_OVERRUN);
    rdc("status", spims_pkg::OFS_STATUS, 32'hD8);
    rdc("rx kept", spims_pkg::OFS_DATA, 32'h3C);
    chk("peer rx", p_rx, 32'h22);
    wr(spims_pkg::OFS_STATUS, 8'h80);
    p_clock_polarity_sel <= 1'b1;
    p_lsb <= 1'b1;
    wr(spims_pkg::OFS_CONTROL, 8'hD2);
    repeat (3) @(posedge clk);
    chk("sck idle", sck_o, 32'h1);
    xfer(8'h35, 8'hC1);
    wait_bit(spims_pkg::STA_DONE);
    rdc("rx lsb", spims_pkg::OFS_DATA, 32'hC1);
    chk("peer rx", p_rx, 32'h35);
    p_ss_n <= 1'b1;
    p_clock_polarity_sel <= 1'b0;
    p_lsb <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      wr(spims_pkg::OFS_STATUS, 8'h80);
      wr(spims_pkg::OFS_CONTROL, 8'h40 | 8'(r));
      wr(spims_pkg::OFS_DATA, 8'h00);
      half_len(n);
      chk("half period", n, 2 << (r > 5 ? 5 : r));
      wait_bit(spims_pkg::STA_DONE);
    end
    $display("test master done");
    wr(spims_pkg::OFS_STATUS, 8'h80);
    wr(spims_pkg::OFS_CONTROL, 8'h48);
    tb_ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("no fault", spims_pkg::OFS_STATUS, 32'h80);
    wr(spims_pkg::OFS_CONTROL, 8'h40);
    repeat (8) @(posedge clk);
    rdc("fault", spims_pkg::OFS_STATUS, 32'h20);
    rdc("fault ctl", spims_pkg::OFS_CONTROL, 32'h0);
    tb_ss_n <= 1'b1;
    chk("miso oe", miso_oe, 32'h0);
    wr(spims_pkg::OFS_STATUS, 8'h80);
    repeat (3) @(posedge clk);
    chk("miso oe", miso_oe, 32'h0);
    spi_byte(1'b0, 8'hFF, v8);
    rdc("ignored", spims_pkg::OFS_STATUS, 32'h80);
    // select held low for the whole byte, peer stays deselected
    tb_ss_n <= 1'b0;
    spi_byte(1'b0, 8'h96, v8);
    chk("slave tx", v8, 32'h0);
    wait_bit(spims_pkg::STA_DONE);
    chk("miso oe", miso_oe, 32'h1);
    rdc("slave rx", spims_pkg::OFS_DATA, 32'h96);
    tb_ss_n <= 1'b1;
    wr(spims_pkg::OFS_STATUS, 8'h80);
    wr(spims_pkg::OFS_CONTROL, 8'h28);
    wr(spims_pkg::OFS_DATA, 8'hC3);
    chk("miso oe", miso_oe, 32'h1);
    spi_byte(1'b1, 8'h5A, v8);
    chk("slave tx", v8, 32'hC3);
    wait_bit(spims_pkg::STA_DONE);
    rdc("slave rx", spims_pkg::OFS_DATA, 32'h5A);
    $display("test slave done");
    stop_test();
  end
endmodule // test_spi_master_slave_port
`default_nettype wire
